/* File: hdl/atast_core.sv */
`timescale 1ns/100ps
module atast_core import atast_pkg::*; (
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       resetn_i,
   // Configuration access
   input  wire logic [7:0] cfg_addr_i,
   input  wire logic       cfg_wr_i,
   input  wire logic       cfg_rd_i,
   input  wire logic [7:0] cfg_wdata_i,
   output logic      [7:0] cfg_rdata_o,
   // Channel requests, bit 0 primary, bit 1 secondary
   input  wire logic [1:0] ch_req_i,
   input  wire logic [1:0] ch_drive_i,
   input  wire logic [1:0] ch_data_i,
   input  wire logic [1:0] ch_dma_i,
   input  wire logic [1:0] ch_write_i,
   // Drive side strobes and status
   output logic      [1:0] ch_cs_o,
   output logic      [1:0] ch_dior_n_o,
   output logic      [1:0] ch_diow_n_o,
   output logic      [1:0] ch_dmack_n_o,
   output logic      [1:0] ch_done_o,
   output logic      [1:0] ch_reject_o
);

   typedef struct packed {
      logic [7:0]            tf;
      logic [2:0][1:0]       setup;
      logic [3:0][7:0]       data;
      logic [1:0][7:0]       fdma;
      logic [7:0]            rdata;
      atast_phase_e [1:0]    phase;
      logic [1:0][4:0]       cnt;
      logic [1:0][4:0]       act;
      logic [1:0][4:0]       rec;
      logic [1:0][4:0]       low_len;
      logic [1:0][4:0]       rec_len;
      logic [1:0]            write;
      logic [1:0]            dma;
      logic [1:0]            cs;
      logic [1:0]            dior_n;
      logic [1:0]            diow_n;
      logic [1:0]            dmack_n;
      logic [1:0]            done;
      logic [1:0]            reject;
   } atast_state_s;

   atast_state_s q;
   atast_state_s n;
   logic [1:0]   accept;

   always_comb begin
      logic [1:0] idx;
      logic [7:0] tv;
      logic [2:0] su;
      logic       bulk;
      idx  = 2'h0;
      tv   = 8'h00;
      su   = 3'h0;
      bulk = 1'b0;
      n    = q;
      accept = 2'h0;

      if (cfg_wr_i) begin
         if (cfg_addr_i == TF_TIMING_OFS) begin
            n.tf = cfg_wdata_i;
         end else if (cfg_addr_i == D0_SETUP_OFS) begin
            n.setup[0] = cfg_wdata_i[SETUP_MSB:SETUP_LSB];
         end else if (cfg_addr_i == D0_DATA_OFS) begin
            n.data[0] = cfg_wdata_i;
         end else if (cfg_addr_i == D1_SETUP_OFS) begin
            n.setup[1] = cfg_wdata_i[SETUP_MSB:SETUP_LSB];
         end else if (cfg_addr_i == D1_DATA_OFS) begin
            n.data[1] = cfg_wdata_i;
         end else if (cfg_addr_i == SEC_SETUP_OFS) begin
            n.setup[2] = cfg_wdata_i[SETUP_MSB:SETUP_LSB]; // [R7]
         end else if (cfg_addr_i == D2_DATA_OFS) begin
            n.data[2] = cfg_wdata_i;
         end else if (cfg_addr_i == D3_DATA_OFS) begin
            n.data[3] = cfg_wdata_i;
         end else if (cfg_addr_i == FDMA0_OFS) begin
            n.fdma[0] = cfg_wdata_i;
         end else if (cfg_addr_i == FDMA1_OFS) begin
            n.fdma[1] = cfg_wdata_i;
         end
      end

      // Read data is held until the next read so software can sample late.
      if (cfg_rd_i) begin
         if (cfg_addr_i == TF_TIMING_OFS) begin
            n.rdata = q.tf;
         end else if (cfg_addr_i == D0_SETUP_OFS) begin
            n.rdata = {q.setup[0], 6'h00};
         end else if (cfg_addr_i == D0_DATA_OFS) begin
            n.rdata = q.data[0];
         end else if (cfg_addr_i == D1_SETUP_OFS) begin
            n.rdata = {q.setup[1], 6'h00};
         end else if (cfg_addr_i == D1_DATA_OFS) begin
            n.rdata = q.data[1];
         end else if (cfg_addr_i == SEC_SETUP_OFS) begin
            n.rdata = {q.setup[2], 6'h00};
         end else if (cfg_addr_i == D2_DATA_OFS) begin
            n.rdata = q.data[2];
         end else if (cfg_addr_i == D3_DATA_OFS) begin
            n.rdata = q.data[3];
         end else if (cfg_addr_i == FDMA0_OFS) begin
            n.rdata = q.fdma[0];
         end else if (cfg_addr_i == FDMA1_OFS) begin
            n.rdata = q.fdma[1];
         end else begin
            n.rdata = 8'h00;
         end
      end

      for (int c = 0; c < 2; c++) begin
         idx = {c[0], ch_drive_i[c]}; // [R8]
         bulk = ch_data_i[c] | ch_dma_i[c];
         n.done[c] = 1'b0;
         n.reject[c] = 1'b0;
         case (q.phase[c])
            PH_IDLE: begin
               if (ch_req_i[c]) begin
                  if ((bulk && q.fdma[c][ch_drive_i[c]]) ||          // [R17]
                      (ch_dma_i[c] && q.fdma[c][1:0] != 2'h0)) begin // [R11]
                     n.reject[c] = 1'b1;
                  end else begin
                     accept[c] = 1'b1;
                     tv = bulk ? q.data[idx] : q.tf; // [R1] [R9]
                     n.act[c] = atast_act_clk(tv[ACT_MSB:ACT_LSB]); // [R2] [R9]
                     n.rec[c] = atast_rec_clk(tv[REC_MSB:REC_LSB]); // [R5]
                     n.write[c] = ch_write_i[c];
                     n.dma[c] = ch_dma_i[c];
                     if (ch_dma_i[c]) begin
                        n.phase[c] = PH_ACTIVE;
                        n.cnt[c] = n.act[c] - 5'h01;
                     end else begin
                        su = (c == 1) ? {1'b0, q.setup[2]} // [R7]
                                      : {1'b0, q.setup[ch_drive_i[c]]};
                        su = su + 3'h1; // [R6]
                        n.phase[c] = PH_SETUP;
                        n.cnt[c] = {2'h0, su} - 5'h01;
                     end
                  end
               end
            end
            PH_SETUP: begin
               if (q.cnt[c] == 5'h00) begin
                  n.phase[c] = PH_ACTIVE; // [R18]
                  n.cnt[c] = q.act[c] - 5'h01;
               end else begin
                  n.cnt[c] = q.cnt[c] - 5'h01;
               end
            end
            PH_ACTIVE: begin
               if (q.cnt[c] == 5'h00) begin
                  n.phase[c] = PH_RECOV; // [R18]
                  n.cnt[c] = q.rec[c] - 5'h01;
               end else begin
                  n.cnt[c] = q.cnt[c] - 5'h01;
               end
            end
            PH_RECOV: begin
               if (q.cnt[c] == 5'h00) begin
                  n.phase[c] = PH_IDLE; // [R18]
                  n.done[c] = 1'b1;
               end else begin
                  n.cnt[c] = q.cnt[c] - 5'h01;
               end
            end
            default: begin
               n.phase[c] = PH_IDLE;
            end
         endcase
         // Address and selects stay up through recovery on non-DMA accesses so the next access never
         // sees them move while a strobe could still be settling.
         n.cs[c] = (n.phase[c] != PH_IDLE) && !n.dma[c]; // [R18]
         n.dior_n[c] = !(n.phase[c] == PH_ACTIVE && !n.write[c]);
         n.diow_n[c] = !(n.phase[c] == PH_ACTIVE && n.write[c]);
         n.dmack_n[c] = !(n.phase[c] == PH_ACTIVE && n.dma[c]);
         n.low_len[c] = (q.phase[c] == PH_ACTIVE) ? q.low_len[c] + 5'h01 : 5'h00;
         n.rec_len[c] = (q.phase[c] == PH_RECOV) ? q.rec_len[c] + 5'h01 : 5'h00;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         q <= '0;
         q.tf <= TIMING_RST;
         q.setup <= {3{SETUP_RST}};
         q.data <= {4{TIMING_RST}};
         q.fdma <= {2{FDMA_RST}};
         q.dior_n <= 2'h3;
         q.diow_n <= 2'h3;
         q.dmack_n <= 2'h3;
      end else begin
         q <= n;
      end
   end

   assign cfg_rdata_o  = q.rdata;
   assign ch_cs_o      = q.cs;
   assign ch_dior_n_o  = q.dior_n;
   assign ch_diow_n_o  = q.diow_n;
   assign ch_dmack_n_o = q.dmack_n;
   assign ch_done_o    = q.done;
   assign ch_reject_o  = q.reject;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   for (genvar g = 0; g < 2; g++) begin : g_chk
      sequence s_strobe_end;
         $rose(q.phase[g] == PH_RECOV);
      endsequence
      sequence s_recov_end;
         $fell(q.phase[g] == PH_RECOV);
      endsequence
      chk_active_len: assert property (s_strobe_end |-> q.low_len[g] == q.act[g]) // [R2] [R9]
         else $error("Strobe active length differs from programmed count.");
      chk_recov_len: assert property (s_recov_end |-> q.rec_len[g] == q.rec[g]) // [R18]
         else $error("Recovery length differs from programmed count.");
      chk_recov_min: assert property (q.phase[g] == PH_ACTIVE |-> q.rec[g] != 5'h00) // [R5]
         else $error("Zero recovery count latched.");
      chk_setup_first: assert property ($fell(q.dior_n[g] & q.diow_n[g]) && !q.dma[g] // [R6]
            |-> $past(q.phase[g] == PH_SETUP) && $past(q.cs[g]))
         else $error("Strobe asserted without preceding address setup.");
      chk_sec_shared: assert property (accept[g] && g == 1 && !ch_dma_i[g] // [R7]
            |=> q.cnt[g] == {3'h0, $past(q.setup[2])})
         else $error("Secondary channel did not use the shared setup count.");
      chk_fast_reject: assert property (q.phase[g] == PH_IDLE && ch_req_i[g] // [R17] [R11]
            && (ch_data_i[g] | ch_dma_i[g]) && q.fdma[g][ch_drive_i[g]]
            |=> q.reject[g] && q.phase[g] == PH_IDLE ##1 !q.reject[g])
         else $error("Fast-DMA drive request was not refused.");
      chk_taskfile_timing: assert property (accept[g] && !ch_data_i[g] && !ch_dma_i[g] // [R1]
            |=> q.act[g] == atast_act_clk($past(q.tf[ACT_MSB:ACT_LSB])))
         else $error("Task-file access not timed from shared register.");
      chk_drive_index: assert property (accept[g] && ch_data_i[g] // [R8]
            |=> q.rec[g] == atast_rec_clk($past(q.data[{g[0], ch_drive_i[g]}][REC_MSB:REC_LSB])))
         else $error("Data access used the wrong drive timing register.");
      chk_done_after: assert property (q.done[g] |-> q.phase[g] == PH_IDLE // [R18]
            && $past(q.phase[g] == PH_RECOV) && q.cs[g] == 1'b0)
         else $error("Completion without a finished recovery phase.");
   end

endmodule : atast_core

/* File: hdl/atast_pkg.sv */
// Functional notes
// (R1) Task-file accesses on both channels use shared task-file timing; address setup is per drive on primary, shared on secondary.
// (R2) Task-file timing: upper nibble active clocks, lower nibble recovery clocks.
// (R3) Value 0xAF gives 10 active clocks and 1 recovery clock.
// (R4) Value 0x32 gives 3 active clocks and 3 recovery clocks.
// (R5) Recovery is never zero clocks; the minimum is one clock.
// (R6) Address-setup field sets setup before strobes; 0x40 gives 2 clocks.
// (R7) Secondary drives share one setup count in bits 7:6; program for slower drive.
// (R8) Per-drive registers indexed 0,1 primary master/slave, 2,3 secondary master/slave.
// (R9) Per-drive data timing sets PIO 16-bit and DMA acknowledge active/recovery nibbles.
// (R10) Value 0x3F gives 3 active clocks and 1 recovery clock.
// (R11) Multiword DMA runs only when both fast-DMA enable bits are zero.
// (R12) Software programs at least the PIO 0 minimum times.
// (R13) Software meets PIO 4 and multiword DMA 0 minimum times.
// (R14) Unspecified recovery is derived as cycle time minus active time.
// (R15) Counts are bus clocks; software rounds nanosecond minimums up.
// (R16) Software sets the drive mode before programming these timings.
// (R17) A drive with fast DMA enabled has its data timing register ignored.
// (R18) Access sequence: address and select, setup, active strobe, recovery. DMA cycles here skip select and setup.
package atast_pkg;

   // Register offsets.
   localparam logic [7:0] TF_TIMING_OFS  = 8'h52;
   localparam logic [7:0] D0_SETUP_OFS   = 8'h53;
   localparam logic [7:0] D0_DATA_OFS    = 8'h54;
   localparam logic [7:0] D1_SETUP_OFS   = 8'h55;
   localparam logic [7:0] D1_DATA_OFS    = 8'h56;
   localparam logic [7:0] SEC_SETUP_OFS  = 8'h57;
   localparam logic [7:0] D2_DATA_OFS    = 8'h58;
   localparam logic [7:0] D3_DATA_OFS    = 8'h5B;
   localparam logic [7:0] FDMA0_OFS      = 8'h70;
   localparam logic [7:0] FDMA1_OFS      = 8'h71;

   // Reset values.
   localparam logic [7:0] TIMING_RST     = 8'h00;
   localparam logic [1:0] SETUP_RST      = 2'h0;
   localparam logic [7:0] FDMA_RST       = 8'h00;

   // Field positions.
   localparam int SETUP_MSB = 7;
   localparam int SETUP_LSB = 6;
   localparam int ACT_MSB   = 7;
   localparam int ACT_LSB   = 4;
   localparam int REC_MSB   = 3;
   localparam int REC_LSB   = 0;

   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_ACTIVE, PH_RECOV} atast_phase_e;

   // Active nibble: value is the clock count, zero stands for sixteen.
   function automatic logic [4:0] atast_act_clk(input logic [3:0] nib);
      atast_act_clk = (nib == 4'h0) ? 5'h10 : {1'b0, nib}; // [R2] [R3] [R4] [R9] [R10]
   endfunction : atast_act_clk

   // Recovery nibble: value plus one, wrapping 0xF to the one-clock minimum.
   function automatic logic [4:0] atast_rec_clk(input logic [3:0] nib);
      atast_rec_clk = (nib == 4'hF) ? 5'h01 : {1'b0, nib} + 5'h01; // [R5] [R3] [R4] [R10]
   endfunction : atast_rec_clk

endpackage : atast_pkg

/* File: sim/atast_drive_model.sv */
`timescale 1ns/100ps
// Counts each phase of one channel's access as a drive would see it on the cable.
// It drives nothing back, because the block has no drive-side inputs to answer on.
module atast_drive_model (
   // Clock and clear
   input  wire logic sys_clk_i,
   input  wire logic clr_i,
   // Channel pins
   input  wire logic cs_i,
   input  wire logic rd_n_i,
   input  wire logic wr_n_i,
   input  wire logic ack_n_i,
   input  wire logic done_i,
   // Measured phase lengths in clocks
   output int        setup_o,
   output int        rd_o,
   output int        wr_o,
   output int        ack_o,
   output int        rec_o
);
   always @(posedge sys_clk_i) begin
      if (clr_i) begin
         {setup_o, rd_o, wr_o, ack_o, rec_o} <= '0;
      end else if (!rd_n_i || !wr_n_i) begin
         rd_o <= rd_o + int'(!rd_n_i);
         wr_o <= wr_o + int'(!wr_n_i);
         ack_o <= ack_o + int'(!ack_n_i);
      end else if (rd_o + wr_o == 0) begin
         setup_o <= setup_o + int'(cs_i);
      end else if (!done_i) begin
         rec_o <= rec_o + 1;
      end
   end
endmodule : atast_drive_model

/* File: sim/tb.sv */
`timescale 1ns/100ps
module tb import atast_pkg::*; ;
   localparam logic [7:0] MAP [10] = '{TF_TIMING_OFS, D0_SETUP_OFS, D0_DATA_OFS, D1_SETUP_OFS,
      D1_DATA_OFS, SEC_SETUP_OFS, D2_DATA_OFS, D3_DATA_OFS, FDMA0_OFS, FDMA1_OFS};
   localparam logic [7:0] DOFS [4] = '{D0_DATA_OFS, D1_DATA_OFS, D2_DATA_OFS, D3_DATA_OFS};
   logic       sys_clk_i = 1'b0;
   logic       resetn_i = 1'b0;
   logic [7:0] cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, cfg_rdata_o;
   logic       cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
   logic [1:0] ch_req_i = '0, ch_drive_i = '0, ch_data_i = '0, ch_dma_i = '0, ch_write_i = '0;
   logic [1:0] clr = '0, ch_cs_o, ch_dior_n_o, ch_diow_n_o, ch_dmack_n_o, ch_done_o, ch_reject_o;
   logic [7:0] mdl [logic [7:0]];
   int         su [2], rdc [2], wrc [2], ackc [2], rec [2];
   int         n_fail = 0, total_checks = 0;

   initial begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   atast_core i_dut (.sys_clk_i, .resetn_i, .cfg_addr_i, .cfg_wr_i, .cfg_rd_i, .cfg_wdata_i,
      .cfg_rdata_o, .ch_req_i, .ch_drive_i, .ch_data_i, .ch_dma_i, .ch_write_i, .ch_cs_o,
      .ch_dior_n_o, .ch_diow_n_o, .ch_dmack_n_o, .ch_done_o, .ch_reject_o);

   for (genvar g = 0; g < 2; g++) begin : g_drv
      atast_drive_model i_drv (.sys_clk_i, .clr_i(clr[g]), .cs_i(ch_cs_o[g]),
         .rd_n_i(ch_dior_n_o[g]), .wr_n_i(ch_diow_n_o[g]), .ack_n_i(ch_dmack_n_o[g]),
         .done_i(ch_done_o[g]), .setup_o(su[g]), .rd_o(rdc[g]), .wr_o(wrc[g]),
         .ack_o(ackc[g]), .rec_o(rec[g]));
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   task automatic tally_and_finish();
      if (n_fail == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   // The setup registers keep only their top two bits, so the model masks the rest.
   task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      {cfg_addr_i, cfg_wdata_i, cfg_wr_i} <= {a, d, 1'b1};
      @(posedge sys_clk_i);
      cfg_wr_i <= 1'b0;
      if (mdl.exists(a)) begin
         mdl[a] = (a inside {D0_SETUP_OFS, D1_SETUP_OFS, SEC_SETUP_OFS}) ? d & 8'hC0 : d;
      end
   endtask : cfg_write

   task automatic cfg_read(input logic [7:0] a);
      @(posedge sys_clk_i);
      {cfg_addr_i, cfg_rd_i} <= {a, 1'b1};
      @(posedge sys_clk_i);
      cfg_rd_i <= 1'b0;
      #1;
      chk("cfg_rdata", mdl.exists(a) ? mdl[a] : 8'h00, cfg_rdata_o);
   endtask : cfg_read

   // Kind 0 is a task-file access, 1 a 16-bit data access, 2 a multiword DMA cycle.
   task automatic run(input int ch, input int d, input int kind);
      logic [7:0] t, f;
      logic       w;
      int         a, r, s, x, i;
      w = 1'($urandom_range(1, 0));
      f = mdl[FDMA0_OFS + 8'(ch)];
      t = (kind == 0) ? mdl[TF_TIMING_OFS] : mdl[DOFS[2 * ch + d]];
      s = (ch ? mdl[SEC_SETUP_OFS] : mdl[d ? D1_SETUP_OFS : D0_SETUP_OFS]) / 64 + 1;
      s = (kind == 2) ? 0 : s;
      a = (t[7:4] == 4'h0) ? 16 : t[7:4];
      r = (t[3:0] == 4'hF) ? 1 : t[3:0] + 1;
      x = (kind == 1 && f[d]) || (kind == 2 && f[1:0] != 2'h0);
      @(posedge sys_clk_i);
      {ch_req_i[ch], ch_drive_i[ch], ch_data_i[ch], ch_dma_i[ch], ch_write_i[ch], clr[ch]}
         <= {1'b1, 1'(d), kind == 1, kind == 2, w, 1'b1};
      @(posedge sys_clk_i);
      {ch_req_i[ch], clr[ch]} <= 2'b00;
      for (i = 0; i < 100; i++) begin
         #1;
         if (ch_done_o[ch] === 1'b1 || ch_reject_o[ch] === 1'b1) break;
         @(posedge sys_clk_i);
      end
      if (i == 100) begin
         n_fail++;
         tally_and_finish();
      end
      chk("reject", x, ch_reject_o[ch]);
      chk("done", !x, ch_done_o[ch]);
      chk("setup clocks", x ? 0 : s, su[ch]);
      chk("read active", (x || w) ? 0 : a, rdc[ch]);
      chk("write active", (x || !w) ? 0 : a, wrc[ch]);
      chk("dack active", (x || kind != 2) ? 0 : a, ackc[ch]);
      chk("recovery", x ? 0 : r, rec[ch]);
   endtask : run

   initial begin
      void'($urandom(32'hAA66));
      foreach (MAP[k]) mdl[MAP[k]] = 8'h00;
      repeat (2) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      foreach (MAP[k]) cfg_read(MAP[k]);
      cfg_read(8'h59);
      cfg_write(TF_TIMING_OFS, 8'hAF);
      cfg_write(D0_SETUP_OFS, 8'h40);
      run(0, 0, 0);
      cfg_write(TF_TIMING_OFS, 8'h32);
      cfg_write(SEC_SETUP_OFS, 8'h40);
      run(1, 1, 0);
      run(1, 0, 0);
      cfg_write(D2_DATA_OFS, 8'h3F);
      run(1, 0, 2);
      run(1, 0, 1);
      cfg_write(FDMA1_OFS, 8'h02);
      run(1, 0, 2);
      run(1, 1, 1);
      run(1, 0, 1);
      run(1, 1, 0);
      cfg_write(FDMA1_OFS, 8'h00);
      cfg_write(D0_DATA_OFS, 8'h0F);
      run(0, 0, 1);
      // Slowest programmed mode: every minimum rounded up to whole bus clocks.
      cfg_write(TF_TIMING_OFS, 8'hA9);
      cfg_write(D0_SETUP_OFS, 8'h80);
      cfg_write(D0_DATA_OFS, 8'h6D);
      run(0, 0, 0);
      run(0, 0, 1);
      cfg_write(D1_DATA_OFS, 8'h88);
      run(0, 1, 2);
      repeat (40) begin
         cfg_write(MAP[$urandom_range(9, 0)], 8'($urandom));
         cfg_write(8'($urandom_range(8'h5F, 8'h50)), 8'($urandom));
         cfg_read(MAP[$urandom_range(9, 0)]);
         run($urandom_range(1, 0), $urandom_range(1, 0), $urandom_range(2, 0));
      end
      tally_and_finish();
   end
endmodule : tb
